// *** rtl/wiper_timer_pkg.sv ***
// constants and types shared by the interval wipe/wash timer
package wiper_timer_pkg;

  // system clock and base oscillator period
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam longint unsigned BASE_PERIOD_PS = 64'd3125000000;
  localparam int unsigned BASE_DIV_CYC = int'(BASE_PERIOD_PS / CLK_PERIOD_PS);

  // durations in base oscillator periods, except PAUSE_TICKS which counts interval ticks
  localparam logic [4:0] DEB_TICKS = 5'h19;
  localparam logic [10:0] ON_TICKS = 11'h078;
  localparam logic [10:0] WASH_DELAY_TICKS = 11'h100;
  localparam logic [10:0] DRY_TICKS = 11'h4A0;
  localparam logic [8:0] PAUSE_TICKS = 9'h128;
  localparam logic [2:0] SC_FULL = 3'h7;

  // interval pauses per switch position, in microseconds
  localparam longint unsigned PAUSE1_US = 64'd5080000;
  localparam longint unsigned PAUSE2_US = 64'd1850000;
  localparam longint unsigned PAUSE3_US = 64'd989000;
  localparam longint unsigned PS_PER_US = 64'd1000000;
  localparam logic [31:0] INT_DIV1_RST =
    32'(PAUSE1_US * PS_PER_US / CLK_PERIOD_PS / 296);
  localparam logic [31:0] INT_DIV2_RST =
    32'(PAUSE2_US * PS_PER_US / CLK_PERIOD_PS / 296);
  localparam logic [31:0] INT_DIV3_RST =
    32'(PAUSE3_US * PS_PER_US / CLK_PERIOD_PS / 296);

  // register byte addresses
  localparam logic [7:0] STATUS_ADDR = 8'h00;
  localparam logic [7:0] INT_DIV1_ADDR = 8'h04;
  localparam logic [7:0] INT_DIV2_ADDR = 8'h08;
  localparam logic [7:0] INT_DIV3_ADDR = 8'h0C;

  // input channels of the debouncer
  localparam int unsigned CH_INT = 0;
  localparam int unsigned CH_WASH = 1;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DELAY = 6'h02,
    ST_WASH = 6'h04,
    ST_DRY = 6'h08,
    ST_PULSE = 6'h10,
    ST_PAUSE = 6'h20
  } seq_state_e;

  // status word layout, first field is the most significant
  typedef struct packed {
    logic [15:0] zero;
    logic [5:0] state;
    logic [1:0] interval_level;
    logic [2:0] sc_shift;
    logic wash_db;
    logic int_db;
    logic load_dump;
    logic fault;
    logic relay;
  } status_s;

endpackage : wiper_timer_pkg

// *** rtl/wiper_timer.sv ***
// interval and wipe/wash relay sequencer with short-circuit cut-off
`timescale 1ns/1ps
module wiper_timer
  import wiper_timer_pkg::*;
#(
  parameter int unsigned BASE_DIV = BASE_DIV_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] interval_level_i,
  input wire logic wash_button_input_i,
  input wire logic delay_select_strap_i,
  input wire logic overcurrent_detect_i,
  input wire logic load_dump_i,
  input wire logic continuous_wipe_i,
  output logic relay_o,
  output logic fault_o
);

  // pin synchronisers: first stage read only by second
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else begin
      sync1_q <= {continuous_wipe_i, load_dump_i, overcurrent_detect_i,
                  delay_select_strap_i, wash_button_input_i, interval_level_i};
      sync2_q <= sync1_q;
    end
  end

  logic [1:0] level_s;
  logic wash_s;
  logic strap_s;
  logic sc_s;
  logic dump_s;
  logic cont_s;
  assign level_s = sync2_q[1:0];
  assign wash_s = sync2_q[2];
  assign strap_s = sync2_q[3];
  assign sc_s = sync2_q[4];
  assign dump_s = sync2_q[5];
  assign cont_s = sync2_q[6];

  // base oscillator tick; free running so input edges land at any phase
  logic [31:0] base_cnt_q;
  logic base_tick;
  assign base_tick = (base_cnt_q == BASE_DIV - 1);
  always_ff @(posedge clk_i) begin
    if (rst_i || base_tick) begin
      base_cnt_q <= 32'h00000000;
    end else begin
      base_cnt_q <= base_cnt_q + 32'h00000001;
    end
  end

  // debouncers for interval and wash requests
  logic [1:0] raw_req;
  logic [1:0] db_q;
  assign raw_req[CH_INT] = (level_s != 2'h0);
  assign raw_req[CH_WASH] = wash_s;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_deb
      logic [4:0] cnt_q;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt_q <= 5'h00;
          db_q[ch] <= 1'b0;
        end else if (raw_req[ch] == db_q[ch]) begin
          cnt_q <= 5'h00;
        end else if (base_tick) begin
          if (cnt_q == DEB_TICKS - 5'h01) begin
            cnt_q <= 5'h00;
            db_q[ch] <= raw_req[ch];
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
      end
    end
  endgenerate

  logic int_db;
  logic wash_db;
  assign int_db = db_q[CH_INT];
  assign wash_db = db_q[CH_WASH];

  // overcurrent shift register and fault latch
  logic [2:0] sc_shift_q;
  logic fault_q;
  logic sc_full;
  assign sc_full = (sc_shift_q == SC_FULL);

  always_ff @(posedge clk_i) begin
    if (rst_i || dump_s) begin
      sc_shift_q <= 3'h0;
    end else if (base_tick) begin
      sc_shift_q <= sc_s ? {sc_shift_q[1:0], 1'b1} : 3'h0;
    end
  end

  // a trip in the clearing cycle wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_q <= 1'b0;
    end else if (sc_full && !dump_s) begin
      fault_q <= 1'b1;
    end else if (!int_db && !wash_db) begin
      fault_q <= 1'b0;
    end
  end

  // interval tick divisors per switch position, software tunable
  logic [31:0] int_div_q [3];
  logic [31:0] int_div_sel;
  always_comb begin
    case (level_s)
      2'h1: int_div_sel = int_div_q[0];
      2'h2: int_div_sel = int_div_q[1];
      default: int_div_sel = int_div_q[2];
    endcase
  end

  seq_state_e state_q;
  seq_state_e state_d;
  logic [10:0] seq_cnt_q;
  logic [8:0] pause_cnt_q;
  logic [31:0] int_div_cnt_q;
  logic int_tick;
  logic seq_done;
  logic pause_done;
  logic [10:0] seq_limit;

  assign int_tick = (int_div_cnt_q >= int_div_sel - 32'h00000001);
  assign pause_done = int_tick && (pause_cnt_q == PAUSE_TICKS - 9'h001);

  always_comb begin
    case (state_q)
      ST_DELAY: seq_limit = WASH_DELAY_TICKS;
      ST_DRY: seq_limit = DRY_TICKS;
      default: seq_limit = ON_TICKS;
    endcase
  end
  assign seq_done = base_tick && (seq_cnt_q == seq_limit - 11'h001);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (wash_db) begin
          state_d = strap_s ? ST_WASH : ST_DELAY;
        end else if (int_db) begin
          state_d = ST_PULSE;
        end
      end
      ST_DELAY: begin
        if (seq_done) begin
          state_d = wash_db ? ST_WASH : ST_DRY;
        end
      end
      ST_WASH: begin
        if (!wash_db) begin
          state_d = ST_DRY;
        end
      end
      ST_DRY: begin
        if (wash_db) begin
          state_d = ST_WASH;
        end else if (seq_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_PULSE: begin
        if (seq_done) begin
          if (wash_db) begin
            state_d = ST_WASH;
          end else if (int_db) begin
            state_d = ST_PAUSE;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_PAUSE: begin
        if (wash_db) begin
          state_d = ST_WASH;
        end else if (!int_db) begin
          state_d = ST_IDLE;
        end else if (pause_done) begin
          state_d = ST_PULSE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // a tripped fault parks the sequencer so only a fresh request restarts it
  always_ff @(posedge clk_i) begin
    if (rst_i || fault_q) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_d != state_q || fault_q) begin
      seq_cnt_q <= 11'h000;
    end else if (base_tick) begin
      seq_cnt_q <= seq_cnt_q + 11'h001;
    end
  end

  // slow interval clock only runs during the pause
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != ST_PAUSE) begin
      int_div_cnt_q <= 32'h00000000;
      pause_cnt_q <= 9'h000;
    end else if (int_tick) begin
      int_div_cnt_q <= 32'h00000000;
      pause_cnt_q <= pause_cnt_q + 9'h001;
    end else begin
      int_div_cnt_q <= int_div_cnt_q + 32'h00000001;
    end
  end

  // relay driver
  logic relay_req;
  assign relay_req = (state_q == ST_WASH) || (state_q == ST_DRY) || (state_q == ST_PULSE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      relay_o <= 1'b0;
    end else if (dump_s) begin
      relay_o <= 1'b1;
    end else if (fault_q || sc_full) begin
      relay_o <= 1'b0;
    end else begin
      relay_o <= cont_s || relay_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_o <= 1'b0;
    end else begin
      fault_o <= fault_q;
    end
  end

  // wishbone slave: one registered ack the cycle after each request, then ack drops
  logic wb_req;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  genvar r;
  genvar b;
  generate
    for (r = 0; r < 3; r++) begin : g_div
      localparam logic [7:0] ADDR = INT_DIV1_ADDR + 8'(4 * r);
      localparam logic [31:0] RST = (r == 0) ? INT_DIV1_RST :
                                    (r == 1) ? INT_DIV2_RST : INT_DIV3_RST;
      for (b = 0; b < 4; b++) begin : g_lane
        always_ff @(posedge clk_i) begin
          if (rst_i) begin
            int_div_q[r][8*b +: 8] <= RST[8*b +: 8];
          end else if (wb_req && wb_we_i && wb_adr_i == ADDR && wb_sel_i[b]) begin
            int_div_q[r][8*b +: 8] <= wb_dat_i[8*b +: 8];
          end
        end
      end
    end
  endgenerate

  status_s status;
  always_comb begin
    status = '0;
    status.state = state_q;
    status.interval_level = level_s;
    status.sc_shift = sc_shift_q;
    status.wash_db = wash_db;
    status.int_db = int_db;
    status.load_dump = dump_s;
    status.fault = fault_q;
    status.relay = relay_o;
  end

  // unmapped addresses read zero and are still acknowledged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_req) begin
      case (wb_adr_i)
        STATUS_ADDR: wb_dat_o <= status;
        INT_DIV1_ADDR: wb_dat_o <= int_div_q[0];
        INT_DIV2_ADDR: wb_dat_o <= int_div_q[1];
        INT_DIV3_ADDR: wb_dat_o <= int_div_q[2];
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

endmodule : wiper_timer

// *** verif/relay_load.sv ***
// relay coil model: draws overcurrent while driven into a shorted load
`timescale 1ns/1ps
module relay_load (
  input wire logic clk_i,
  input wire logic relay_i,
  input wire logic short_i,
  output logic overcurrent_o
);
  // the shunt sees current only while the driver conducts
  always_ff @(posedge clk_i) begin
    overcurrent_o <= relay_i & short_i;
  end
endmodule : relay_load

// *** verif/wiper_timer_props.sv ***
// concurrent checks on the wiper timer ports
`timescale 1ns/1ps
module wiper_timer_props
  import wiper_timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [1:0] interval_level_i,
  input wire logic wash_button_input_i,
  input wire logic overcurrent_detect_i,
  input wire logic load_dump_i,
  input wire logic continuous_wipe_i,
  input wire logic relay_o,
  input wire logic fault_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [6:0] act_q;
  // saturates so a long press never wraps back under the threshold
  always_ff @(posedge clk_i) begin
    if (rst_i || (interval_level_i == 2'h0 && !wash_button_input_i)) act_q <= 7'h00;
    else if (act_q != 7'h7F) act_q <= act_q + 7'h01;
  end
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ld_quiet; (!load_dump_i) [*4]; endsequence
  property p_reset; $fell(rst_i) |-> !relay_o && !fault_o; endproperty
  property p_ack; s_req |=> wb_ack_o; endproperty
  property p_no_ack; !wb_stb_i |=> !wb_ack_o; endproperty
  property p_unmapped; s_req ##0 !wb_we_i && wb_adr_i == 8'h40 |=> wb_dat_o == 32'h0; endproperty
  property p_fault_cut; s_ld_quiet ##0 (fault_o && $past(fault_o)) |-> !relay_o; endproperty
  property p_ld_on; load_dump_i [*4] |-> relay_o; endproperty
  // a trip in progress may cut the relay one cycle before the fault pin shows it
  property p_cont; (continuous_wipe_i && !fault_o) [*4] |-> (relay_o or (##1 fault_o)); endproperty
  // the three samples of the shift register, four cycles apart with the bench divider
  property p_trip;
    $rose(fault_o) |-> $past(overcurrent_detect_i, 5) && $past(overcurrent_detect_i, 9)
      && $past(overcurrent_detect_i, 13) && !$past(load_dump_i, 4);
  endproperty
  property p_fault_hold; act_q >= 7'h70 && fault_o |=> fault_o; endproperty
  a_reset: assert property (p_reset) else $error("outputs not clear after reset");
  a_ack: assert property (p_ack) else $error("no ack one cycle after request");
  a_no_ack: assert property (p_no_ack) else $error("ack without request");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_fault_cut: assert property (p_fault_cut) else $error("relay on during fault");
  a_ld_on: assert property (p_ld_on) else $error("relay off in load dump");
  a_cont: assert property (p_cont) else $error("relay off in continuous wipe");
  a_trip: assert property (p_trip) else $error("fault without steady overcurrent");
  a_fault_hold: assert property (p_fault_hold) else $error("fault cleared while active");
endmodule : wiper_timer_props
bind wiper_timer wiper_timer_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .interval_level_i, .wash_button_input_i,
  .overcurrent_detect_i, .load_dump_i, .continuous_wipe_i, .relay_o, .fault_o);

// *** verif/tb.sv ***
// self-checking bench for the wiper timer
`timescale 1ns/1ps
module tb
  import wiper_timer_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, relay_o, fault_o, overcurrent_detect_i, short_q = 1'b0;
  logic [1:0] interval_level_i = 2'h0;
  logic wash_button_input_i = 1'b0, delay_select_strap_i = 1'b1;
  logic load_dump_i = 1'b0, continuous_wipe_i = 1'b0, ok;
  int miscompares = 0, cmp_count = 0, n, w;
  wiper_timer #(.BASE_DIV(4)) dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .interval_level_i, .wash_button_input_i,
    .delay_select_strap_i, .overcurrent_detect_i, .load_dump_i, .continuous_wipe_i,
    .relay_o, .fault_o);
  relay_load u_load (.clk_i, .relay_i(relay_o), .short_i(short_q),
    .overcurrent_o(overcurrent_detect_i));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task close_out();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  task chk(input logic c, input string msg);
    cmp_count++;
    if (c !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    if (k >= 20) begin
      chk(1'b0, "bus timeout");
      close_out();
    end
  endtask : wb
  // waits on relay (f=0) or fault (f=1); a hang ends the run
  task wt(input logic f, input logic v, input int lim);
    n = 0;
    while ((f ? fault_o : relay_o) !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim) begin
      chk(1'b0, "wait timeout");
      close_out();
    end
  endtask : wt
  task quiet(input int cyc);
    ok = 1'b1;
    repeat (cyc) begin
      @(posedge clk_i);
      if (relay_o !== 1'b0) ok = 1'b0;
    end
    chk(ok, "relay on with no request");
  endtask : quiet
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(relay_o === 1'b0 && fault_o === 1'b0, "reset state");
    wb(1'b0, STATUS_ADDR, 32'h00000000);
    chk(rd === 32'h00000400, "status reset");
    wb(1'b0, INT_DIV1_ADDR, 32'h00000000);
    chk(rd === INT_DIV1_RST, "divider reset");
    // short interval tick so a whole pause fits the run
    wb(1'b1, INT_DIV1_ADDR, 32'h00000004);
    wb(1'b0, INT_DIV1_ADDR, 32'h00000000);
    chk(rd === 32'h00000004, "div");
    wb(1'b1, 8'h40, 32'h000000FF);
    wb(1'b0, 8'h40, 32'h00000000);
    chk(rd === 32'h00000000, "unmapped");
    quiet(200);
    // strap low: debounce plus the 256 tick delay before turn-on
    delay_select_strap_i <= 1'b0;
    wash_button_input_i <= 1'b1;
    wt(1'b0, 1'b1, 1300);
    chk(n >= 1116 && n <= 1136, "wash delay");
    wash_button_input_i <= 1'b0;
    wt(1'b0, 1'b0, 5000);
    chk(n >= 4820 && n <= 4850, "dry wipe");
    delay_select_strap_i <= 1'b1;
    wash_button_input_i <= 1'b1;
    wt(1'b0, 1'b1, 300);
    chk(n >= 96 && n <= 112, "no delay");
    wash_button_input_i <= 1'b0;
    wt(1'b0, 1'b0, 5000);
    // press released inside the delay still ends in a dry wipe
    delay_select_strap_i <= 1'b0;
    wash_button_input_i <= 1'b1;
    repeat (300) @(posedge clk_i);
    wash_button_input_i <= 1'b0;
    wt(1'b0, 1'b1, 1000);
    chk(n >= 816 && n <= 836, "short press delay");
    wt(1'b0, 1'b0, 5000);
    chk(n >= 4730 && n <= 4740, "short press dry");
    delay_select_strap_i <= 1'b1;
    interval_level_i <= 2'h1;
    wt(1'b0, 1'b1, 300);
    chk(n >= 96 && n <= 112, "interval start");
    wt(1'b0, 1'b0, 600);
    chk(n >= 476 && n <= 484, "pulse length");
    wt(1'b0, 1'b1, 1400);
    chk(n >= 1176 && n <= 1192, "pause length");
    interval_level_i <= 2'h0;
    wt(1'b0, 1'b0, 600);
    chk(n >= 476 && n <= 484, "finish pulse");
    quiet(1500);
    interval_level_i <= 2'h1;
    delay_select_strap_i <= 1'b0;
    wt(1'b0, 1'b1, 300);
    wt(1'b0, 1'b0, 600);
    wash_button_input_i <= 1'b1;
    wt(1'b0, 1'b1, 300);
    chk(n >= 96 && n <= 112, "wash beats interval");
    wash_button_input_i <= 1'b0;
    wt(1'b0, 1'b0, 5000);
    wt(1'b0, 1'b1, 1400);
    chk(n <= 1192, "interval resumes");
    interval_level_i <= 2'h0;
    delay_select_strap_i <= 1'b1;
    wt(1'b0, 1'b0, 600);
    short_q <= 1'b1;
    interval_level_i <= 2'h3;
    wt(1'b0, 1'b1, 300);
    wt(1'b0, 1'b0, 30);
    chk(n >= 8 && n <= 20, "trip time");
    // the latch reaches its pin one cycle after the relay is cut
    @(posedge clk_i);
    chk(fault_o === 1'b1, "fault latched");
    quiet(300);
    interval_level_i <= 2'h0;
    wt(1'b1, 1'b0, 200);
    chk(n >= 96, "fault clear on release");
    interval_level_i <= 2'h2;
    wt(1'b0, 1'b1, 300);
    wt(1'b0, 1'b0, 30);
    @(posedge clk_i);
    chk(fault_o === 1'b1, "persistent short trips again");
    interval_level_i <= 2'h0;
    wt(1'b1, 1'b0, 200);
    short_q <= 1'b0;
    interval_level_i <= 2'h2;
    wt(1'b0, 1'b1, 300);
    chk(fault_o === 1'b0, "re-enable");
    interval_level_i <= 2'h0;
    wt(1'b0, 1'b0, 600);
    continuous_wipe_i <= 1'b1;
    wt(1'b0, 1'b1, 10);
    continuous_wipe_i <= 1'b0;
    wt(1'b0, 1'b0, 10);
    short_q <= 1'b1;
    load_dump_i <= 1'b1;
    wt(1'b0, 1'b1, 10);
    repeat (100) @(posedge clk_i);
    chk(relay_o === 1'b1 && fault_o === 1'b0, "load dump ignores overcurrent");
    short_q <= 1'b0;
    load_dump_i <= 1'b0;
    wt(1'b0, 1'b0, 10);
    close_out();
  end
endmodule : tb
